// File: rx_status_defines.vh
// Constants for the asynchronous serial receive status block.
`ifndef RX_STATUS_DEFINES_VH
`define RX_STATUS_DEFINES_VH

// Width of one FIFO entry: framing bit, ninth bit, eight data bits.
`define RX_ENTRY_W      10
`define RX_FRAME_ERROR_FLAG_BIT     9
`define RX_NINTH_BIT    8
`define RX_FIFO_DEPTH   2
// Bit-time counter reload for the line sampler; one bit lasts this value plus one system clock.
`define RX_BIT_CYCLES   16'd868
`define RX_HALF_CYCLES  16'd434

`endif

// File: rx_char_fifo.v
// Two-entry character FIFO with valid and ready on both sides.
`default_nettype none
`include "rx_status_defines.vh"

module rx_char_fifo #(
    parameter W = `RX_ENTRY_W
) (
    // Clock and reset
    input  wire         i_clk,
    input  wire         i_rst,
    input  wire         i_flush,
    // Fill side
    input  wire         i_in_valid,
    output wire         o_in_ready,
    input  wire [W-1:0] i_in_data,
    // Drain side
    output wire         o_out_valid,
    input  wire         i_out_ready,
    output wire [W-1:0] o_out_data
);

    reg [W-1:0] mem_ff [0:1];
    reg         rd_ptr_ff;
    reg         wr_ptr_ff;
    reg [1:0]   count_ff;

    wire push = i_in_valid && (count_ff != 2'd2);
    wire pop  = i_out_ready && (count_ff != 2'd0);

    assign o_in_ready  = (count_ff != 2'd2);
    assign o_out_valid = (count_ff != 2'd0);
    assign o_out_data  = mem_ff[rd_ptr_ff];

    // Entries are written whole and read in order, so the fields stay together.
    always @(posedge i_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= i_in_data;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_ptr_ff <= 1'b0;
            wr_ptr_ff <= 1'b0;
            count_ff  <= 2'd0;
        end else if (i_flush) begin
            rd_ptr_ff <= 1'b0;
            wr_ptr_ff <= 1'b0;
            count_ff  <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule // rx_char_fifo
`default_nettype wire

// File: rx_status.v
// Receiver with framing, overrun, nine-bit and address detection status.
`default_nettype none
`include "rx_status_defines.vh"

module rx_status (
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_rst,
    // Serial line
    input  wire       i_rx_line,
    // Control bits
    input  wire       i_serial_port_enable,
    input  wire       i_continuous_receive_enable,
    input  wire       i_nine_bit_receive_select,
    input  wire       i_address_detect_enable,
    input  wire       i_rx_irq_enable,
    input  wire       i_peripheral_irq_enable,
    input  wire       i_global_irq_enable,
    // Data read strobe
    input  wire       i_data_read,
    // Status and data
    output reg        o_rx_pending_flag,
    output reg        o_frame_error_flag,
    output reg        o_overrun_error_flag,
    output reg        o_ninth_data_bit,
    output reg  [7:0] o_receive_data,
    output reg        o_rx_irq
);

    // ****************************************************************
    // Line synchroniser and sampler
    // ****************************************************************
    localparam ST_IDLE  = 4'b0001;
    localparam ST_START = 4'b0010;
    localparam ST_DATA  = 4'b0100;
    localparam ST_STOP  = 4'b1000;

    reg        sync1_ff;
    reg        sync2_ff;
    reg        sync3_ff;
    reg        line_ff;
    reg [3:0]  state_ff;
    reg [15:0] tick_ff;
    reg [3:0]  bit_cnt_ff;
    reg [8:0]  shift_ff;
    reg        done_ff;
    reg [9:0]  done_word_ff;
    reg        overrun_ff;

    wire rx_on = i_serial_port_enable && i_continuous_receive_enable;
    wire [3:0] bits_needed = i_nine_bit_receive_select ? 4'd9 : 4'd8;

    // A change counts only once the second and third stages agree.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            sync3_ff <= 1'b1;
            line_ff  <= 1'b1;
        end else begin
            sync1_ff <= i_rx_line;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (sync2_ff == sync3_ff) begin
                line_ff <= sync3_ff;
            end
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff     <= ST_IDLE;
            tick_ff      <= 16'd0;
            bit_cnt_ff   <= 4'd0;
            shift_ff     <= 9'h000;
            done_ff      <= 1'b0;
            done_word_ff <= 10'h000;
        end else if (!rx_on) begin
            state_ff <= ST_IDLE;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (!line_ff) begin
                        state_ff <= ST_START;
                        tick_ff  <= `RX_HALF_CYCLES;
                    end
                end
                ST_START: begin
                    if (tick_ff != 16'd0) begin
                        tick_ff <= tick_ff - 16'd1;
                    end else if (line_ff) begin
                        state_ff <= ST_IDLE;
                    end else begin
                        state_ff   <= ST_DATA;
                        tick_ff    <= `RX_BIT_CYCLES;
                        bit_cnt_ff <= 4'd0;
                    end
                end
                ST_DATA: begin
                    if (tick_ff != 16'd0) begin
                        tick_ff <= tick_ff - 16'd1;
                    end else begin
                        // LSB first; nine-bit mode shifts one more bit.
                        shift_ff   <= {line_ff, shift_ff[8:1]};
                        bit_cnt_ff <= bit_cnt_ff + 4'd1;
                        tick_ff    <= `RX_BIT_CYCLES;
                        if (bit_cnt_ff + 4'd1 == bits_needed) begin
                            state_ff <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    if (tick_ff != 16'd0) begin
                        tick_ff <= tick_ff - 16'd1;
                    end else begin
                        // Missing stop bit marks the entry; reception goes on.
                        state_ff <= ST_IDLE;
                        done_ff  <= 1'b1;
                        if (i_nine_bit_receive_select) begin
                            done_word_ff <= {~line_ff, shift_ff};
                        end else begin
                            done_word_ff <= {~line_ff, 1'b0, shift_ff[8:1]};
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Queueing, address filter and overrun
    // ****************************************************************
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [9:0] fifo_out_data;

    // Address filter only acts in nine-bit mode.
    wire addr_mode = i_address_detect_enable && i_nine_bit_receive_select;
    wire accept    = done_ff && !(addr_mode && !done_word_ff[`RX_NINTH_BIT]);
    wire push      = accept && !overrun_ff && fifo_in_ready;
    wire pop       = i_data_read && fifo_out_valid;

    // Flush only on port disable, so receive disable keeps the stored status.
    rx_char_fifo #(
        .W (`RX_ENTRY_W)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_flush     (!i_serial_port_enable),
        .i_in_valid  (push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (done_word_ff),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (pop),
        .o_out_data  (fifo_out_data)
    );

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            overrun_ff <= 1'b0;
        end else if (!rx_on) begin
            overrun_ff <= 1'b0;
        end else if (accept && !fifo_in_ready) begin
            overrun_ff <= 1'b1;
        end
    end

    // ****************************************************************
    // Registered status outputs
    // ****************************************************************
    // Outputs lag the FIFO by one cycle so they come straight from flops.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rx_pending_flag    <= 1'b0;
            o_frame_error_flag   <= 1'b0;
            o_overrun_error_flag <= 1'b0;
            o_ninth_data_bit     <= 1'b0;
            o_receive_data       <= 8'h00;
            o_rx_irq             <= 1'b0;
        end else begin
            // Follows occupancy; gated only by the port enable.
            o_rx_pending_flag <= i_serial_port_enable && fifo_out_valid;
            // Oldest entry's fields, cleared when port disabled.
            // Gated by the port enable so the flag drops on the disabling edge itself.
            o_frame_error_flag <= i_serial_port_enable && fifo_out_valid
                                  && fifo_out_data[`RX_FRAME_ERROR_FLAG_BIT];
            o_ninth_data_bit   <= fifo_out_valid && fifo_out_data[`RX_NINTH_BIT];
            o_receive_data     <= fifo_out_valid ? fifo_out_data[7:0] : 8'h00;
            // Gated by the enables so the flag falls with the clearing edge.
            o_overrun_error_flag <= overrun_ff && rx_on;
            // Framing error plays no part here.
            o_rx_irq <= i_serial_port_enable && fifo_out_valid && i_rx_irq_enable
                        && i_peripheral_irq_enable && i_global_irq_enable;
        end
    end

endmodule // rx_status
`default_nettype wire

// File: rx_status_properties.sv
// Port-level checks for the serial receive status block.
`default_nettype none
module rx_status_properties (
    // Clock, reset and controls
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_serial_port_enable,
    input wire logic       i_continuous_receive_enable,
    input wire logic       i_rx_irq_enable,
    input wire logic       i_peripheral_irq_enable,
    input wire logic       i_global_irq_enable,
    input wire logic       i_data_read,
    // Status and data
    input wire logic       o_rx_pending_flag,
    input wire logic       o_frame_error_flag,
    input wire logic       o_overrun_error_flag,
    input wire logic       o_ninth_data_bit,
    input wire logic [7:0] o_receive_data,
    input wire logic       o_rx_irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic spe, all_en;
    assign spe = i_serial_port_enable;
    assign all_en = i_rx_irq_enable && i_peripheral_irq_enable && i_global_irq_enable;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_pend_port_off: assert property (!spe [*2] |-> !o_rx_pending_flag && !o_frame_error_flag)
        else $error("pending or framing flag with port off");
    a_irq_gated: assert property (!all_en ##1 !all_en |-> !o_rx_irq)
        else $error("interrupt without all enables");
    a_irq_follows: assert property ((all_en && o_rx_pending_flag) [*3] |-> o_rx_irq)
        else $error("interrupt missing while pending");
    a_irq_no_pend: assert property (!o_rx_pending_flag [*2] |-> !o_rx_irq)
        else $error("interrupt without pending data");
    a_ovr_hold: assert property (o_overrun_error_flag && i_continuous_receive_enable && spe
        |=> o_overrun_error_flag)
        else $error("overrun cleared while enabled");
    a_ovr_clear: assert property (!i_continuous_receive_enable [*2] |-> !o_overrun_error_flag)
        else $error("overrun kept with receive off");
    a_ovr_full: assert property ($rose(o_overrun_error_flag) |-> o_rx_pending_flag)
        else $error("overrun with buffer not full");
    a_head_stable: assert property (o_rx_pending_flag && spe && !i_data_read && !$past(i_data_read)
        |=> $stable({o_receive_data, o_ninth_data_bit, o_frame_error_flag}))
        else $error("oldest entry changed without a read");
    a_empty_clear: assert property (spe [*3] ##0 !o_rx_pending_flag
        |-> !o_frame_error_flag && o_receive_data == 8'h00)
        else $error("status shown with empty buffer");
endmodule // rx_status_properties
bind rx_status rx_status_properties u_props (.i_clk(i_clk), .i_rst(i_rst),
    .i_serial_port_enable(i_serial_port_enable),
    .i_continuous_receive_enable(i_continuous_receive_enable),
    .i_rx_irq_enable(i_rx_irq_enable), .i_peripheral_irq_enable(i_peripheral_irq_enable),
    .i_global_irq_enable(i_global_irq_enable), .i_data_read(i_data_read),
    .o_rx_pending_flag(o_rx_pending_flag), .o_frame_error_flag(o_frame_error_flag),
    .o_overrun_error_flag(o_overrun_error_flag), .o_ninth_data_bit(o_ninth_data_bit),
    .o_receive_data(o_receive_data), .o_rx_irq(o_rx_irq));
`default_nettype wire

// File: rx_line_driver.sv
// Remote serial transmitter model that drives the receive line.
`default_nettype none
`include "rx_status_defines.vh"
module rx_line_driver (
    // Clock and line
    input  wire logic i_clk,
    output var  logic o_line
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BIT = `RX_BIT_CYCLES + 1;
    initial o_line = 1'b1;
    // Start, data LSB first, stop, then one idle bit so a bad stop still
    // leaves a clean falling edge for the next start.
    task automatic send(input logic [8:0] d, input logic nine, input logic bad_stop);
        int nb;
        nb = nine ? 9 : 8;
        for (int i = 0; i <= nb + 2; i++) begin
            o_line = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : (i == nb + 1) ? ~bad_stop : 1'b1;
            repeat (BIT) @(posedge i_clk);
            #1;
        end
    endtask
endmodule // rx_line_driver
`default_nettype wire

// File: async_serial_receive_status_test.sv
// Self-checking bench for the serial receive status block.
`default_nettype none
module async_serial_receive_status_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic       i_clk, i_rst, line, spe, continuous_receive_enable, nine, address_detect_enable, rie, pie, global_irq_enable, rd;
    logic       pend, frame_error_flag, ovr, b9, irq;
    logic [7:0] data;
    logic [9:0] q[$];
    int         n_fail = 0;
    int         checked = 0;
    rx_status u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_rx_line(line),
        .i_serial_port_enable(spe), .i_continuous_receive_enable(continuous_receive_enable),
        .i_nine_bit_receive_select(nine), .i_address_detect_enable(address_detect_enable),
        .i_rx_irq_enable(rie), .i_peripheral_irq_enable(pie), .i_global_irq_enable(global_irq_enable),
        .i_data_read(rd), .o_rx_pending_flag(pend), .o_frame_error_flag(frame_error_flag),
        .o_overrun_error_flag(ovr), .o_ninth_data_bit(b9), .o_receive_data(data),
        .o_rx_irq(irq));
    rx_line_driver u_tx (.i_clk(i_clk), .o_line(line));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic put(input logic [8:0] d, input logic bad, input logic keep);
        u_tx.send(d, nine, bad);
        if (keep) q.push_back({bad, nine & d[8], d[7:0]});
    endtask
    task automatic rd_one;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        tick(2);
    endtask
    // Status is taken at the read edge, before the pop moves the head.
    always @(posedge i_clk) begin
        if (rd && pend) chk("entry", {frame_error_flag, b9, data}, q.pop_front());
    end
    initial begin
        #900us;
        n_fail++;
        end_of_test();
    end
    initial begin
        i_rst = 1'b1;
        {spe, continuous_receive_enable, nine, address_detect_enable, rie, pie, global_irq_enable, rd} = 8'h00;
        void'($urandom(32'hb7fc));
        tick(8);
        i_rst = 1'b0;
        spe = 1'b1;
        continuous_receive_enable = 1'b1;
        tick(2);
        put(9'($urandom), 0, 1);
        put(9'($urandom), 1, 1);
        put(9'($urandom), 0, 0);
        chk("overrun", {ovr, pend}, 2'b11);
        rd_one();
        chk("frame", frame_error_flag, 1'b1);
        put(9'($urandom), 0, 0);
        chk("blocked", {ovr, pend}, 2'b11);
        for (int m = 0; m < 8; m++) begin
            {rie, pie, global_irq_enable} = m[2:0];
            tick(3);
            chk("irq", {pend, irq}, {1'b1, m == 7});
        end
        continuous_receive_enable = 1'b0;
        tick(3);
        chk("receive off", {ovr, frame_error_flag}, 2'b01);
        continuous_receive_enable = 1'b1;
        spe = 1'b0;
        tick(3);
        chk("port off", {pend, frame_error_flag, irq, ovr}, 4'h0);
        void'(q.pop_front());
        spe = 1'b1;
        $display("overrun and framing test done");
        nine = 1'b1;
        tick(2);
        put(9'h100 | 9'($urandom), 0, 1);
        rd_one();
        address_detect_enable = 1'b1;
        put(9'($urandom) & 9'h0ff, 0, 0);
        chk("dropped", pend, 1'b0);
        put(9'h100 | 9'($urandom), 0, 1);
        chk("address", pend, 1'b1);
        address_detect_enable = 1'b0;
        rd_one();
        chk("drained", {pend, q.size() == 0}, 2'b01);
        $display("nine-bit and address test done");
        end_of_test();
    end
endmodule // async_serial_receive_status_test
`default_nettype wire
